// file: rtl/tdc_defines.vh
// Constants for the time-of-day counter: offsets, fields, reset values
// Operation
// (R1) Start request raises run status within two source cycles
// (R2) Stop request clears run status within three source cycles
// (R3) Software waits for status before other accesses
// (R4) Time and setup registers written only while stopped
// (R5) Stopped only when request and status both zero
// (R6) Software writes control two last before start
// (R7) Compare registers written only while not busy
// (R8) Busy flag high while time data is rewritten
// (R9) Periodic event sets the interrupt request flag
// (R10) Software may double-read time until values match
// (R11) Software reads several time registers back to back
// (R12) Time fields laid out as tens and units
// (R13) Seconds carry through minutes, hours, weekday, afternoon
// (R14) Count source synchronised to meet start and stop bounds
`ifndef TDC_DEFINES_VH
`define TDC_DEFINES_VH

`define TDC_ADR_SEC 8'h00
`define TDC_ADR_MIN 8'h04
`define TDC_ADR_HR 8'h08
`define TDC_ADR_WK 8'h0C
`define TDC_ADR_CTL1 8'h10
`define TDC_ADR_CTL2 8'h14
`define TDC_ADR_CSS 8'h18
`define TDC_ADR_CSEC 8'h1C
`define TDC_ADR_CMIN 8'h20
`define TDC_ADR_CHR 8'h24
`define TDC_ADR_IRQ 8'h28
`define TDC_ADR_MASK 8'h2C

`define TDC_CTL1_RUN 0
`define TDC_CTL1_STAT 1
`define TDC_CTL1_H24 2
`define TDC_CTL1_PM 3
`define TDC_SEC_BUSY 7
`define TDC_CTL2_CMPEN 2
`define TDC_IRQ_PER 0
`define TDC_IRQ_CMP 1

`define TDC_CSS_RESET 5'h0F
`define TDC_HR_RESET 6'h12
`define TDC_WK_LAST 3'h6

`endif

// file: rtl/tdc_sync.v
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module tdc_sync (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire d, // Asynchronous level
  output wire q // Synchronised level
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end
  assign q = s2_ff;
endmodule

// file: rtl/tdc_top.v
// Time-of-day counter with Wishbone register slave and interrupt
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ns
`include "tdc_defines.vh"
module tdc_top #(
  parameter PRESC_W = 32
) (
  input wire SYS_CLK, // System clock
  input wire RST, // Synchronous reset, active high
  input wire CNT_SRC, // Count source pin
  input wire WB_CYC_I, // Bus cycle
  input wire WB_STB_I, // Strobe
  input wire WB_WE_I, // Write enable
  input wire [7:0] WB_ADR_I, // Byte address
  input wire [3:0] WB_SEL_I, // Byte selects
  input wire [31:0] WB_DAT_I, // Write data
  output wire [31:0] WB_DAT_O, // Read data
  output wire WB_ACK_O, // Acknowledge
  output wire IRQ // Level interrupt
);
  reg ack_ff;
  reg [31:0] rdat_ff;
  reg cs_prev_ff;
  reg run_req_ff;
  reg run_stat_ff;
  reg h24_ff;
  reg pm_ff;
  reg [3:0] sec_u_ff;
  reg [2:0] sec_t_ff;
  reg [3:0] min_u_ff;
  reg [2:0] min_t_ff;
  reg [3:0] hr_u_ff;
  reg [1:0] hr_t_ff;
  reg [2:0] wk_ff;
  reg [1:0] per_sel_ff;
  reg cmp_en_ff;
  reg [4:0] css_ff;
  reg [6:0] csec_ff;
  reg [6:0] cmin_ff;
  reg [5:0] chr_ff;
  reg [1:0] irq_st_ff;
  reg [1:0] irq_mask_ff;
  reg busy_ff;
  reg [PRESC_W-1:0] presc_ff;
  wire cs_sync;
  wire cs_tick;
  wire acc;
  wire wr;
  wire rd;
  wire stopped;
  wire sec_tick;
  wire [PRESC_W-1:0] presc_top;
  reg [3:0] nxt_sec_u;
  reg [2:0] nxt_sec_t;
  reg [3:0] nxt_min_u;
  reg [2:0] nxt_min_t;
  reg [3:0] nxt_hr_u;
  reg [1:0] nxt_hr_t;
  reg [2:0] nxt_wk;
  reg nxt_pm;
  reg c_min;
  reg c_hr;
  reg c_day;
  reg per_evt;
  reg cmp_evt;
  reg [31:0] nxt_rdat;

  tdc_sync u_cs_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d(CNT_SRC),
    .q(cs_sync)
  );

  // One pulse per rising edge of the count source
  assign cs_tick = cs_sync & ~cs_prev_ff; // R14
  assign acc = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign wr = acc & WB_WE_I & WB_SEL_I[0];
  assign rd = acc & ~WB_WE_I;
  assign stopped = ~run_req_ff & ~run_stat_ff; // R5
  assign presc_top = {{(PRESC_W-1){1'b0}}, 1'b1} << css_ff;
  assign sec_tick = cs_tick & run_stat_ff &
    (presc_ff == presc_top - {{(PRESC_W-1){1'b0}}, 1'b1});
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;
  assign IRQ = |(irq_st_ff & irq_mask_ff);

  // Carry chain for one second step
  always @* begin
    nxt_sec_u = sec_u_ff + 4'h1;
    nxt_sec_t = sec_t_ff;
    nxt_min_u = min_u_ff;
    nxt_min_t = min_t_ff;
    nxt_hr_u = hr_u_ff;
    nxt_hr_t = hr_t_ff;
    nxt_wk = wk_ff;
    nxt_pm = pm_ff;
    c_min = 1'b0;
    c_hr = 1'b0;
    c_day = 1'b0;
    if (sec_u_ff == 4'h9) begin // R13
      nxt_sec_u = 4'h0;
      nxt_sec_t = sec_t_ff + 3'h1;
      if (sec_t_ff == 3'h5) begin
        nxt_sec_t = 3'h0;
        c_min = 1'b1;
      end
    end
    if (c_min) begin
      nxt_min_u = min_u_ff + 4'h1;
      if (min_u_ff == 4'h9) begin
        nxt_min_u = 4'h0;
        nxt_min_t = min_t_ff + 3'h1;
        if (min_t_ff == 3'h5) begin
          nxt_min_t = 3'h0;
          c_hr = 1'b1;
        end
      end
    end
    if (c_hr) begin
      nxt_hr_u = hr_u_ff + 4'h1;
      if (hr_u_ff == 4'h9) begin
        nxt_hr_u = 4'h0;
        nxt_hr_t = hr_t_ff + 2'h1;
      end
      if (h24_ff) begin
        if (hr_t_ff == 2'h2 && hr_u_ff == 4'h3) begin
          nxt_hr_t = 2'h0;
          nxt_hr_u = 4'h0;
          c_day = 1'b1;
        end
      end else begin
        if (hr_t_ff == 2'h1 && hr_u_ff == 4'h1) begin
          nxt_pm = ~pm_ff; // R13
          c_day = pm_ff;
        end
        if (hr_t_ff == 2'h1 && hr_u_ff == 4'h2) begin
          nxt_hr_t = 2'h0;
          nxt_hr_u = 4'h1;
        end
      end
    end
    if (c_day) begin
      nxt_wk = (wk_ff == `TDC_WK_LAST) ? 3'h0 : wk_ff + 3'h1;
    end
    case (per_sel_ff)
      2'h0: per_evt = 1'b1;
      2'h1: per_evt = c_min;
      2'h2: per_evt = c_hr;
      2'h3: per_evt = c_day;
      default: per_evt = 1'b0;
    endcase
    cmp_evt = cmp_en_ff && {nxt_sec_t, nxt_sec_u} == csec_ff &&
      {nxt_min_t, nxt_min_u} == cmin_ff &&
      {nxt_hr_t, nxt_hr_u} == chr_ff;
  end

  // Register read mux
  always @* begin
    nxt_rdat = 32'h0000_0000;
    case (WB_ADR_I)
      `TDC_ADR_SEC: nxt_rdat[7:0] = {busy_ff, sec_t_ff, sec_u_ff}; // R12
      `TDC_ADR_MIN: nxt_rdat[6:0] = {min_t_ff, min_u_ff};
      `TDC_ADR_HR: nxt_rdat[5:0] = {hr_t_ff, hr_u_ff};
      `TDC_ADR_WK: nxt_rdat[2:0] = wk_ff;
      `TDC_ADR_CTL1: nxt_rdat[3:0] = {pm_ff, h24_ff, run_stat_ff,
        run_req_ff};
      `TDC_ADR_CTL2: nxt_rdat[2:0] = {cmp_en_ff, per_sel_ff};
      `TDC_ADR_CSS: nxt_rdat[4:0] = css_ff;
      `TDC_ADR_CSEC: nxt_rdat[6:0] = csec_ff;
      `TDC_ADR_CMIN: nxt_rdat[6:0] = cmin_ff;
      `TDC_ADR_CHR: nxt_rdat[5:0] = chr_ff;
      `TDC_ADR_IRQ: nxt_rdat[1:0] = irq_st_ff;
      `TDC_ADR_MASK: nxt_rdat[1:0] = irq_mask_ff;
      default: nxt_rdat = 32'h0000_0000;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
      cs_prev_ff <= 1'b0;
      run_req_ff <= 1'b0;
      run_stat_ff <= 1'b0;
      h24_ff <= 1'b0;
      pm_ff <= 1'b0;
      sec_u_ff <= 4'h0;
      sec_t_ff <= 3'h0;
      min_u_ff <= 4'h0;
      min_t_ff <= 3'h0;
      hr_u_ff <= 4'h2;
      hr_t_ff <= 2'h1;
      wk_ff <= 3'h0;
      per_sel_ff <= 2'h0;
      cmp_en_ff <= 1'b0;
      css_ff <= `TDC_CSS_RESET;
      csec_ff <= 7'h00;
      cmin_ff <= 7'h00;
      chr_ff <= 6'h00;
      irq_st_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
      busy_ff <= 1'b0;
      presc_ff <= {PRESC_W{1'b0}};
    end else begin
      ack_ff <= acc;
      rdat_ff <= rd ? nxt_rdat : 32'h0000_0000;
      cs_prev_ff <= cs_sync;
      // Status follows request on the next count-source rising edge
      if (cs_tick) begin
        run_stat_ff <= run_req_ff; // R1 R2
      end
      if (!run_stat_ff) begin
        presc_ff <= {PRESC_W{1'b0}};
      end else if (cs_tick) begin
        if (sec_tick) begin
          presc_ff <= {PRESC_W{1'b0}};
        end else begin
          presc_ff <= presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};
        end
      end
      // Busy for one cycle, then time data rewritten
      busy_ff <= sec_tick; // R8
      if (busy_ff) begin
        sec_u_ff <= nxt_sec_u; // R13
        sec_t_ff <= nxt_sec_t;
        min_u_ff <= nxt_min_u;
        min_t_ff <= nxt_min_t;
        hr_u_ff <= nxt_hr_u;
        hr_t_ff <= nxt_hr_t;
        wk_ff <= nxt_wk;
        pm_ff <= nxt_pm;
      end
      // Read clears status; a same-cycle event wins
      if (rd && WB_ADR_I == `TDC_ADR_IRQ) begin
        irq_st_ff <= 2'h0;
      end
      if (busy_ff && per_evt) begin
        irq_st_ff[`TDC_IRQ_PER] <= 1'b1; // R9
      end
      if (busy_ff && cmp_evt) begin
        irq_st_ff[`TDC_IRQ_CMP] <= 1'b1;
      end
      if (wr) begin
        case (WB_ADR_I)
          `TDC_ADR_CTL1: begin
            run_req_ff <= WB_DAT_I[`TDC_CTL1_RUN]; // R1 R2
            if (stopped) begin // R4
              h24_ff <= WB_DAT_I[`TDC_CTL1_H24];
              pm_ff <= WB_DAT_I[`TDC_CTL1_PM];
            end
          end
          `TDC_ADR_SEC: if (stopped) begin // R4
            sec_u_ff <= WB_DAT_I[3:0];
            sec_t_ff <= WB_DAT_I[6:4];
          end
          `TDC_ADR_MIN: if (stopped) begin
            min_u_ff <= WB_DAT_I[3:0];
            min_t_ff <= WB_DAT_I[6:4];
          end
          `TDC_ADR_HR: if (stopped) begin
            hr_u_ff <= WB_DAT_I[3:0];
            hr_t_ff <= WB_DAT_I[5:4];
          end
          `TDC_ADR_WK: if (stopped) begin
            wk_ff <= WB_DAT_I[2:0];
          end
          `TDC_ADR_CTL2: if (stopped) begin
            per_sel_ff <= WB_DAT_I[1:0];
            cmp_en_ff <= WB_DAT_I[`TDC_CTL2_CMPEN];
          end
          `TDC_ADR_CSS: if (stopped) begin
            css_ff <= WB_DAT_I[4:0];
          end
          `TDC_ADR_CSEC: if (!busy_ff) begin // R7
            csec_ff <= WB_DAT_I[6:0];
          end
          `TDC_ADR_CMIN: if (!busy_ff) begin
            cmin_ff <= WB_DAT_I[6:0];
          end
          `TDC_ADR_CHR: if (!busy_ff) begin
            chr_ff <= WB_DAT_I[5:0];
          end
          `TDC_ADR_MASK: irq_mask_ff <= WB_DAT_I[1:0];
          default: ;
        endcase
      end
    end
  end
endmodule

// file: verif/tdc_monitor.sv
// Bus and run-status checker for the time-of-day counter
`timescale 1ns/1ns
`include "tdc_defines.vh"
module tdc_monitor (
  input wire SYS_CLK, // Clock
  input wire RST, // Reset
  input wire CNT_SRC, // Source
  input wire WB_CYC_I, // Cycle
  input wire WB_STB_I, // Strobe
  input wire WB_WE_I, // Write
  input wire [7:0] WB_ADR_I, // Address
  input wire [3:0] WB_SEL_I, // Selects
  input wire [31:0] WB_DAT_I, // Wdata
  input wire [31:0] WB_DAT_O, // Rdata
  input wire WB_ACK_O, // Ack
  input wire IRQ // Irq
);
  reg src_ff, run_ff, mask_ff;
  reg [2:0] edge_ff;
  wire rd = WB_ACK_O & ~WB_WE_I;
  wire wr = WB_ACK_O & WB_WE_I & WB_SEL_I[0];
  wire ctl_wr = wr & (WB_ADR_I == `TDC_ADR_CTL1);
  wire ctl_rd = rd & (WB_ADR_I == `TDC_ADR_CTL1);
  // Rising source edges since the last control write
  always @(posedge SYS_CLK) begin
    src_ff <= CNT_SRC;
    if (RST | ctl_wr)
      edge_ff <= 3'h0;
    else if (CNT_SRC & ~src_ff & (edge_ff != 3'h7))
      edge_ff <= edge_ff + 3'h1;
    if (RST)
      run_ff <= 1'b0;
    else if (ctl_wr)
      run_ff <= WB_DAT_I[0];
    if (RST)
      mask_ff <= 1'b0;
    else if (wr & (WB_ADR_I == `TDC_ADR_MASK))
      mask_ff <= |WB_DAT_I[1:0];
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  ack_one_cycle_a:
    assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  ack_next_cycle_a:
    assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack late");
  ack_idle_a:
    assert property (!WB_CYC_I |=> !WB_ACK_O) else $error("ack unasked");
  data_idle_a:
    assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("dirty data");
  start_bound_a:
    assert property (ctl_rd && run_ff && edge_ff >= 3'h3 |-> WB_DAT_O[1])
      else $error("run status late");
  stop_bound_a:
    assert property (ctl_rd && !run_ff && edge_ff >= 3'h4 |-> !WB_DAT_O[1])
      else $error("stop status late");
  sec_layout_a:
    assert property (rd && WB_ADR_I == `TDC_ADR_SEC |-> WB_DAT_O[6:4] <= 3'h5
      && WB_DAT_O[3:0] <= 4'h9 && WB_DAT_O[31:8] == 24'h0)
      else $error("seconds out of range");
  masked_quiet_a:
    assert property (!mask_ff |-> !IRQ) else $error("masked irq");
endmodule
bind tdc_top tdc_monitor mon (.SYS_CLK(SYS_CLK), .RST(RST), .CNT_SRC(CNT_SRC),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ));

// file: verif/testbench.sv
// Self-checking bench for the time-of-day counter
`timescale 1ns/1ns
`include "tdc_defines.vh"
module testbench;
  reg clk, rst, src, cyc, stb, we;
  reg [7:0] adr;
  reg [31:0] di, q, q0;
  wire [31:0] dq;
  wire ack, irq;
  integer errors, cmp_count, k;
  tdc_top dut (.SYS_CLK(clk), .RST(rst), .CNT_SRC(src), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(di), .WB_DAT_O(dq), .WB_ACK_O(ack), .IRQ(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count source period of ten clocks
  always @(posedge clk) begin
    k <= (k == 4) ? 0 : k + 1;
    if (k == 4)
      src <= ~src;
  end
  task wrap_up;
    begin
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("BAD %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      {cyc, stb, we, adr, di} <= {2'b11, w, a, d};
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, ack}, 32'h1);
      if (n == 20)
        wrap_up;
      q = dq;
      {cyc, stb} <= 2'b00;
      @(posedge clk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wb(1'b1, a, d);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      wb(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  // Only the status bit is read while it settles
  task poll(input v, input integer lim);
    integer n;
    begin
      n = 0;
      do begin
        wb(1'b0, `TDC_ADR_CTL1, 32'h0);
        n = n + 1;
      end while (q[1] !== v && n < lim);
      chk({31'h0, q[1]}, {31'h0, v});
    end
  endtask
  task t_reset;
    begin
      rdc(`TDC_ADR_CTL1, 32'h0);
      rdc(`TDC_ADR_HR, {26'h0, `TDC_HR_RESET});
      rdc(`TDC_ADR_CSS, {27'h0, `TDC_CSS_RESET});
      rdc(8'h3C, 32'h0);
    end
  endtask
  task t_run;
    integer n;
    begin
      wr(`TDC_ADR_CSS, 32'h2);
      wr(`TDC_ADR_SEC, 32'h59);
      wr(`TDC_ADR_MIN, 32'h59);
      wr(`TDC_ADR_HR, 32'h11);
      wr(`TDC_ADR_WK, 32'h6);
      wr(`TDC_ADR_CTL1, 32'h8);
      wr(`TDC_ADR_MASK, 32'h1);
      wr(`TDC_ADR_CTL2, 32'h0);
      wr(`TDC_ADR_CTL1, 32'h9);
      poll(1'b1, 7);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, irq}, 32'h1);
      rdc(`TDC_ADR_IRQ, 32'h1);
      rdc(`TDC_ADR_IRQ, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rdc(`TDC_ADR_SEC, 32'h0);
      rdc(`TDC_ADR_MIN, 32'h0);
      rdc(`TDC_ADR_HR, 32'h12);
      rdc(`TDC_ADR_WK, 32'h0);
      rdc(`TDC_ADR_CTL1, 32'h3);
      wr(`TDC_ADR_HR, 32'h5);
      rdc(`TDC_ADR_HR, 32'h12);
      wr(`TDC_ADR_MASK, 32'h0);
      repeat (50) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rdc(`TDC_ADR_IRQ, 32'h1);
      // Two matching reads give a coherent time
      wb(1'b0, `TDC_ADR_SEC, 32'h0);
      q0 = q;
      rdc(`TDC_ADR_SEC, q0);
    end
  endtask
  task t_stop;
    begin
      wr(`TDC_ADR_CTL1, 32'h0);
      poll(1'b0, 10);
      wr(`TDC_ADR_SEC, 32'h10);
      rdc(`TDC_ADR_SEC, 32'h10);
      wr(`TDC_ADR_CSEC, 32'h25);
      rdc(`TDC_ADR_CSEC, 32'h25);
    end
  endtask
  // 24-hour rollover with minute event and compare match
  task t_h24;
    integer n;
    begin
      wr(`TDC_ADR_SEC, 32'h59);
      wr(`TDC_ADR_MIN, 32'h59);
      wr(`TDC_ADR_HR, 32'h23);
      wr(`TDC_ADR_WK, 32'h2);
      wr(`TDC_ADR_CTL1, 32'h4);
      wr(`TDC_ADR_CSEC, 32'h0);
      wr(`TDC_ADR_CMIN, 32'h0);
      wr(`TDC_ADR_CHR, 32'h0);
      wb(1'b0, `TDC_ADR_IRQ, 32'h0);
      wr(`TDC_ADR_MASK, 32'h3);
      wr(`TDC_ADR_CTL2, 32'h5);
      wr(`TDC_ADR_CTL1, 32'h5);
      poll(1'b1, 7);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, irq}, 32'h1);
      rdc(`TDC_ADR_IRQ, 32'h3);
      rdc(`TDC_ADR_SEC, 32'h0);
      rdc(`TDC_ADR_MIN, 32'h0);
      rdc(`TDC_ADR_HR, 32'h0);
      rdc(`TDC_ADR_WK, 32'h3);
      rdc(`TDC_ADR_CTL1, 32'h7);
    end
  endtask
  initial begin
    {errors, cmp_count, k} = 0;
    rst = 1'b1;
    {src, cyc, stb, we, adr, di, q, q0} = 108'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_run;
    t_stop;
    t_h24;
    wrap_up;
  end
endmodule
